// ### common/rxcfg_regs.svh
// Purpose: field positions, reset values, limits and timing counts of the command decoder
// Assumes: 16-bit control words, msb first
// Notes:   definitions only
`ifndef RXCFG_REGS_SVH
`define RXCFG_REGS_SVH

`define RXCFG_WORD_W        16
`define RXCFG_POR_CFG       16'h928A
`define RXCFG_POR_FREQ      16'hAD57
`define RXCFG_POR_RX        16'hC080
`define RXCFG_POR_SYNC      16'hC1D4
`define RXCFG_POR_WAKE      16'hE196
`define RXCFG_POR_WAKEX     16'hC300
`define RXCFG_SYNC_HIGH     8'h2D
`define RXCFG_FREQ_MIN      12'h060
`define RXCFG_FREQ_MAX      12'hF3F
`define RXCFG_TAIL_LONG     10'h200
`define RXCFG_TAIL_SHORT    10'h080
`define RXCFG_BIT_BATT      10
`define RXCFG_BIT_WAKE      9
`define RXCFG_BIT_XTAL      8
`define RXCFG_BIT_CLKOFF    0
`define RXCFG_BIT_RXON      0
`define RXCFG_MS_NS         1000000
`define RXCFG_CLK_NS        10
`define RXCFG_MS_CYCLES     (`RXCFG_MS_NS / `RXCFG_CLK_NS)

`endif

// ### common/rxcfg_pkg.sv
// Purpose: types of the command decoder
// Assumes: nothing
// Notes:   command kinds from the fixed upper bits
package rxcfg_pkg;
    typedef enum logic [2:0] {
        CMD_NONE, CMD_CFG, CMD_FREQ, CMD_WAKE, CMD_RX, CMD_SYNC, CMD_WAKEX
    } rxcfg_cmd_e;
    typedef enum logic [1:0] {
        BAND_RSVD, BAND_433, BAND_868, BAND_915
    } rxcfg_band_e;
endpackage : rxcfg_pkg

// ### rtl/rxcfg_decoder.sv
// Purpose: serial command decoder holding receiver settings
// Assumes: serial pins are asynchronous, sampled by core_clk
// Notes:   wake-up period counted in milliseconds from a core_clk divider
`timescale 1ns/1ps
`default_nettype none
`include "rxcfg_regs.svh"

module rxcfg_decoder #(
    parameter int MS_CYCLES = `RXCFG_MS_CYCLES
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // serial control pins
    input  wire logic        sel_n,
    input  wire logic        ser_clk,
    input  wire logic        ser_din,
    // inputs from other command groups
    input  wire logic        slow_clk_on,
    input  wire logic        duty_cycle_on,
    input  wire logic        long_clock_tail,
    // receive status sources
    input  wire logic        digital_strength_flag,
    input  wire logic        signal_quality_flag,
    input  wire logic        clock_lock_flag,
    // decoded settings
    output logic [1:0]       band_select,
    output logic [3:0]       band_n,
    output logic [3:0]       band_c,
    output logic             battery_monitor_on,
    output logic             wake_timer_on,
    output logic             xtal_keep_on,
    output logic [3:0]       xtal_load_sel,
    output logic [2:0]       baseband_width_sel,
    output logic             baseband_width_rsvd,
    output logic             clock_out_off,
    output logic             clock_out_en,
    output logic             osc32k_on,
    output logic             xtal_osc_on,
    output logic [11:0]      lo_freq_value,
    output logic [1:0]       valid_flag_select,
    output logic             valid_data_flag,
    output logic [1:0]       amp_gain_sel,
    output logic [2:0]       strength_threshold_sel,
    output logic             receiver_chain_on,
    output logic [15:0]      sync_pattern,
    output logic [13:0]      wake_mantissa,
    output logic [3:0]       wake_exponent,
    output logic [1:0]       wake_exp_reduction,
    output logic             wake_irq
);
    initial begin
        if (MS_CYCLES < 2) $error("MS_CYCLES too small");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage read only by second
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic       sck_d_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1_ff <= 3'h1;
            sync2_ff <= 3'h1;
            sck_d_ff <= 1'b0;
        end else begin
            sync1_ff <= {ser_din, ser_clk, sel_n};
            sync2_ff <= sync1_ff;
            sck_d_ff <= sync2_ff[1];
        end
    end
    wire sel_n_s = sync2_ff[0];
    wire din_s   = sync2_ff[2];
    wire sck_rise = sync2_ff[1] & ~sck_d_ff;

    ////////////////////////////////////////////////////////////////////////////
    // shift register; word completes on the 16th bit, further bits ignored
    logic [15:0] shift_ff;
    logic [4:0]  bitcnt_ff;
    logic        word_stb_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shift_ff    <= 16'h0000;
            bitcnt_ff   <= 5'h00;
            word_stb_ff <= 1'b0;
        end else begin
            word_stb_ff <= 1'b0;
            if (sel_n_s) begin
                bitcnt_ff <= 5'h00;
            end else if (sck_rise && bitcnt_ff != 5'h10) begin
                shift_ff  <= {shift_ff[14:0], din_s};
                bitcnt_ff <= bitcnt_ff + 5'h01;
                word_stb_ff <= (bitcnt_ff == 5'h0F);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command recognition by fixed upper bits
    rxcfg_pkg::rxcfg_cmd_e cmd;
    always_comb begin
        cmd = rxcfg_pkg::CMD_NONE;
        if (shift_ff[15:13] == 3'h4)       cmd = rxcfg_pkg::CMD_CFG;
        else if (shift_ff[15:12] == 4'hA)  cmd = rxcfg_pkg::CMD_FREQ;
        else if (shift_ff[15:12] == 4'hE)  cmd = rxcfg_pkg::CMD_WAKE;
        else if (shift_ff[15:8] == 8'hC0)  cmd = rxcfg_pkg::CMD_RX;
        else if (shift_ff[15:8] == 8'hC1)  cmd = rxcfg_pkg::CMD_SYNC;
        else if (shift_ff[15:8] == 8'hC3)  cmd = rxcfg_pkg::CMD_WAKEX;
    end

    ////////////////////////////////////////////////////////////////////////////
    // command registers
    logic [15:0] cfg_ff;
    logic [15:0] freq_ff;
    logic [15:0] rx_ff;
    logic [15:0] sync_ff;
    logic [15:0] wake_ff;
    logic [15:0] wakex_ff;
    wire freq_ok = shift_ff[11:0] >= `RXCFG_FREQ_MIN && shift_ff[11:0] <= `RXCFG_FREQ_MAX;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_ff   <= `RXCFG_POR_CFG;
            freq_ff  <= `RXCFG_POR_FREQ;
            rx_ff    <= `RXCFG_POR_RX;
            sync_ff  <= `RXCFG_POR_SYNC;
            wake_ff  <= `RXCFG_POR_WAKE;
            wakex_ff <= `RXCFG_POR_WAKEX;
        end else if (word_stb_ff) begin
            case (cmd)
                rxcfg_pkg::CMD_CFG:   cfg_ff   <= shift_ff;
                rxcfg_pkg::CMD_FREQ: begin
                    if (freq_ok) freq_ff <= shift_ff;
                end
                rxcfg_pkg::CMD_WAKE:  wake_ff  <= shift_ff;
                rxcfg_pkg::CMD_RX:    rx_ff    <= shift_ff;
                rxcfg_pkg::CMD_SYNC:  sync_ff  <= shift_ff;
                rxcfg_pkg::CMD_WAKEX: wakex_ff <= shift_ff;
                default: ;
            endcase
        end
    end

    a_freq_range: assert property (@(posedge core_clk) disable iff (rst)
        freq_ff[11:0] >= `RXCFG_FREQ_MIN && freq_ff[11:0] <= `RXCFG_FREQ_MAX)
        else $error("stored frequency out of range");
    a_freq_hold: assert property (@(posedge core_clk) disable iff (rst)
        word_stb_ff && cmd == rxcfg_pkg::CMD_FREQ && !freq_ok |=> $stable(freq_ff))
        else $error("out of range frequency changed value");
    a_cmd_isolate: assert property (@(posedge core_clk) disable iff (rst)
        word_stb_ff && cmd != rxcfg_pkg::CMD_CFG |=> $stable(cfg_ff))
        else $error("configuration changed by other command");
    a_rx_isolate: assert property (@(posedge core_clk) disable iff (rst)
        word_stb_ff && cmd == rxcfg_pkg::CMD_RX |=> $stable(battery_monitor_on)
        && $stable(wake_timer_on))
        else $error("receiver word touched timer or detector");
    a_word_count: assert property (@(posedge core_clk) disable iff (rst)
        word_stb_ff |-> bitcnt_ff == 5'h10)
        else $error("word strobe without sixteen bits");
    a_bit_cap: assert property (@(posedge core_clk) disable iff (rst)
        bitcnt_ff <= 5'h10)
        else $error("bit counter past sixteen");
    a_cfg_write: assert property (@(posedge core_clk) disable iff (rst)
        word_stb_ff && cmd == rxcfg_pkg::CMD_CFG |=> cfg_ff == $past(shift_ff))
        else $error("configuration word not stored");
    a_sync_write: assert property (@(posedge core_clk) disable iff (rst)
        word_stb_ff && cmd == rxcfg_pkg::CMD_SYNC |=> sync_ff == $past(shift_ff))
        else $error("sync word not stored");
    a_wake_isolate: assert property (@(posedge core_clk) disable iff (rst)
        word_stb_ff && cmd != rxcfg_pkg::CMD_WAKE && cmd != rxcfg_pkg::CMD_WAKEX
        |=> $stable(wake_ff) && $stable(wakex_ff))
        else $error("wake words changed by other command");

    ////////////////////////////////////////////////////////////////////////////
    // field decode
    always_comb begin
        band_select = cfg_ff[12:11];
        case (band_select)
            rxcfg_pkg::BAND_433: begin band_n = 4'h4; band_c = 4'hA; end
            rxcfg_pkg::BAND_868: begin band_n = 4'h8; band_c = 4'hA; end
            rxcfg_pkg::BAND_915: begin band_n = 4'h8; band_c = 4'hB; end
            default:             begin band_n = 4'h0; band_c = 4'h0; end
        endcase
    end
    assign battery_monitor_on  = cfg_ff[`RXCFG_BIT_BATT];
    assign wake_timer_on       = cfg_ff[`RXCFG_BIT_WAKE];
    assign xtal_keep_on        = cfg_ff[`RXCFG_BIT_XTAL];
    assign xtal_load_sel       = cfg_ff[7:4];
    assign baseband_width_sel  = cfg_ff[3:1];
    assign baseband_width_rsvd = cfg_ff[3:1] == 3'h0 || cfg_ff[3:1] > 3'h5;
    assign clock_out_off       = cfg_ff[`RXCFG_BIT_CLKOFF];
    assign osc32k_on = slow_clk_on | duty_cycle_on | battery_monitor_on | wake_timer_on;
    assign lo_freq_value       = freq_ff[11:0];
    assign valid_flag_select   = rx_ff[7:6];
    assign amp_gain_sel        = rx_ff[5:4];
    assign strength_threshold_sel = rx_ff[3:1];
    assign receiver_chain_on   = rx_ff[`RXCFG_BIT_RXON];
    assign sync_pattern        = {`RXCFG_SYNC_HIGH, sync_ff[7:0]};
    assign wake_mantissa       = {wakex_ff[5:0], wake_ff[7:0]};
    assign wake_exponent       = wake_ff[11:8];
    assign wake_exp_reduction  = wakex_ff[7:6];

    always_comb begin
        case (valid_flag_select)
            2'h0:    valid_data_flag = digital_strength_flag;
            2'h1:    valid_data_flag = signal_quality_flag;
            2'h2:    valid_data_flag = clock_lock_flag;
            default: valid_data_flag = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // field checks; reserved band reads as zero so no synthesiser setting leaks
    a_band_433: assert property (@(posedge core_clk) disable iff (rst)
        band_select == 2'h1 |-> band_n == 4'h4 && band_c == 4'hA)
        else $error("433 band constants wrong");
    a_band_868: assert property (@(posedge core_clk) disable iff (rst)
        band_select == 2'h2 |-> band_n == 4'h8 && band_c == 4'hA)
        else $error("868 band constants wrong");
    a_band_915: assert property (@(posedge core_clk) disable iff (rst)
        band_select == 2'h3 |-> band_n == 4'h8 && band_c == 4'hB)
        else $error("915 band constants wrong");
    a_band_rsvd: assert property (@(posedge core_clk) disable iff (rst)
        band_select == 2'h0 |-> band_n == 4'h0 && band_c == 4'h0)
        else $error("reserved band gave constants");
    a_osc_on: assert property (@(posedge core_clk) disable iff (rst)
        slow_clk_on || duty_cycle_on || battery_monitor_on || wake_timer_on |-> osc32k_on)
        else $error("slow oscillator off while needed");
    a_osc_off: assert property (@(posedge core_clk) disable iff (rst)
        !slow_clk_on && !duty_cycle_on && !battery_monitor_on && !wake_timer_on |-> !osc32k_on)
        else $error("slow oscillator on while unused");
    a_valid_strength: assert property (@(posedge core_clk) disable iff (rst)
        valid_flag_select == 2'h0 |-> valid_data_flag == digital_strength_flag)
        else $error("valid flag not from strength");
    a_valid_quality: assert property (@(posedge core_clk) disable iff (rst)
        valid_flag_select == 2'h1 |-> valid_data_flag == signal_quality_flag)
        else $error("valid flag not from quality");
    a_valid_lock: assert property (@(posedge core_clk) disable iff (rst)
        valid_flag_select == 2'h2 |-> valid_data_flag == clock_lock_flag)
        else $error("valid flag not from lock");
    a_valid_high: assert property (@(posedge core_clk) disable iff (rst)
        valid_flag_select == 2'h3 |-> valid_data_flag)
        else $error("valid flag not high");
    a_sync_high: assert property (@(posedge core_clk) disable iff (rst)
        sync_pattern[15:8] == `RXCFG_SYNC_HIGH)
        else $error("sync upper byte wrong");
    a_bw_rsvd: assert property (@(posedge core_clk) disable iff (rst)
        baseband_width_sel inside {3'h0, 3'h6, 3'h7} |-> baseband_width_rsvd)
        else $error("reserved bandwidth not flagged");
    a_bw_valid: assert property (@(posedge core_clk) disable iff (rst)
        baseband_width_sel inside {[3'h1:3'h5]} |-> !baseband_width_rsvd)
        else $error("valid bandwidth flagged reserved");

    ////////////////////////////////////////////////////////////////////////////
    // clock tail: crystal held after keep-on drops while clock output is on, counted in clock pulses;
    // the pulse source is the crystal, here counted in core_clk cycles
    logic [9:0] tail_ff;
    logic       keep_d_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tail_ff   <= 10'h000;
            keep_d_ff <= 1'b0; // matches power-on keep bit, so no false fall
        end else begin
            keep_d_ff <= xtal_keep_on;
            if (keep_d_ff && !xtal_keep_on && !clock_out_off) begin
                tail_ff <= long_clock_tail ? `RXCFG_TAIL_LONG : `RXCFG_TAIL_SHORT;
            end else if (xtal_keep_on) begin
                tail_ff <= 10'h000;
            end else if (tail_ff != 10'h000) begin
                tail_ff <= tail_ff - 10'h001;
            end
        end
    end
    // keep_d_ff bridges the cycle before the tail count is loaded
    assign xtal_osc_on  = xtal_keep_on | receiver_chain_on | keep_d_ff | (tail_ff != 10'h000);
    assign clock_out_en = xtal_osc_on & ~clock_out_off;

    a_tail_len: assert property (@(posedge core_clk) disable iff (rst)
        $fell(xtal_keep_on) && !clock_out_off && long_clock_tail
        |=> tail_ff == `RXCFG_TAIL_LONG)
        else $error("long clock tail not loaded");
    a_tail_short: assert property (@(posedge core_clk) disable iff (rst)
        $fell(xtal_keep_on) && !clock_out_off && !long_clock_tail
        |=> tail_ff == `RXCFG_TAIL_SHORT)
        else $error("short clock tail not loaded");
    a_rx_xtal: assert property (@(posedge core_clk) disable iff (rst)
        receiver_chain_on |-> xtal_osc_on)
        else $error("receiver on without crystal");
    a_keep_xtal: assert property (@(posedge core_clk) disable iff (rst)
        xtal_keep_on |-> xtal_osc_on)
        else $error("keep-on set without crystal");
    a_clk_off: assert property (@(posedge core_clk) disable iff (rst)
        clock_out_off |-> !clock_out_en)
        else $error("clock output active while disabled");
    a_tail_off: assert property (@(posedge core_clk) disable iff (rst)
        tail_ff == 10'h000 && !xtal_keep_on && !receiver_chain_on && !keep_d_ff |-> !xtal_osc_on)
        else $error("crystal on after tail ended");

    ////////////////////////////////////////////////////////////////////////////
    // wake-up timer: ms tick, then M * 2^(R-C) ms; negative shift divides
    logic [31:0] ms_div_ff;
    logic        ms_tick_ff;
    logic [31:0] wake_cnt_ff;
    logic [31:0] period;
    logic signed [5:0] shamt;
    always_comb begin
        shamt = $signed({2'b00, wake_exponent}) - $signed({4'b0000, wake_exp_reduction});
        if (shamt >= 0) period = {18'h00000, wake_mantissa} << shamt[4:0];
        else period = {18'h00000, wake_mantissa} >> (-shamt);
    end
    always_ff @(posedge core_clk) begin
        if (rst || !wake_timer_on) begin
            ms_div_ff  <= 32'h00000000;
            ms_tick_ff <= 1'b0;
        end else begin
            ms_tick_ff <= (ms_div_ff == MS_CYCLES - 1);
            ms_div_ff  <= (ms_div_ff == MS_CYCLES - 1) ? 32'h00000000 : ms_div_ff + 32'h00000001;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst || !wake_timer_on) begin
            wake_cnt_ff <= 32'h00000000;
            wake_irq    <= 1'b0;
        end else begin
            wake_irq <= 1'b0;
            if (ms_tick_ff) begin
                if (wake_cnt_ff + 32'h00000001 >= period) begin
                    wake_cnt_ff <= 32'h00000000;
                    wake_irq    <= 1'b1;
                end else begin
                    wake_cnt_ff <= wake_cnt_ff + 32'h00000001;
                end
            end
        end
    end

    a_wake_off: assert property (@(posedge core_clk) disable iff (rst)
        !wake_timer_on |=> !wake_irq)
        else $error("wake interrupt while timer off");
    a_wake_pulse: assert property (@(posedge core_clk) disable iff (rst)
        wake_irq |=> !wake_irq)
        else $error("wake interrupt longer than one cycle");
    a_wake_expire: assert property (@(posedge core_clk) disable iff (rst)
        ms_tick_ff && wake_timer_on && wake_cnt_ff + 32'h00000001 >= period |=> wake_irq)
        else $error("wake interrupt missing at expiry");
    a_ms_tick: assert property (@(posedge core_clk) disable iff (rst)
        ms_tick_ff |=> !ms_tick_ff)
        else $error("millisecond tick longer than one cycle");
endmodule : rxcfg_decoder
`default_nettype wire

// ### sim/rxcfg_host_model.sv
// Purpose: host microcontroller model driving the serial control pins
// Assumes: core_clk at 100 MHz, serial clock period 160 ns
// Notes:   serial clock stands low outside frames; data shows inverse of last bit
`timescale 1ns/1ps
`default_nettype none
module rxcfg_host_model (
    // clock
    input  wire logic core_clk,
    // serial pins
    output logic      sel_n,
    output logic      ser_clk,
    output logic      ser_din
);
    initial begin
        sel_n   = 1'b1;
        ser_clk = 1'b0;
        ser_din = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one whole word per select; 8 core cycles each clock phase, well over the minimum
    task automatic send(input logic [15:0] word);
        @(posedge core_clk);
        sel_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        for (int i = 15; i >= 0; i--) begin
            ser_din <= word[i];
            repeat (8) @(posedge core_clk);
            ser_clk <= 1'b1;
            repeat (8) @(posedge core_clk);
            ser_clk <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        sel_n   <= 1'b1;
        ser_din <= ~word[0];
        repeat (8) @(posedge core_clk);
    endtask : send
endmodule : rxcfg_host_model
`default_nettype wire

// ### sim/tb_rxcfg_decoder.sv
// Purpose: self-checking bench of the serial command decoder
// Assumes: host model drives the serial pins, core_clk 100 MHz
// Notes:   millisecond divider shortened to 10 cycles to keep wake periods short
`timescale 1ns/1ps
`default_nettype none
module tb_rxcfg_decoder;
    localparam int MS = 10;
    logic core_clk = 1'b0, rst = 1'b1, mon_on = 1'b0;
    logic slow_clk_on = 1'b0, duty_cycle_on = 1'b0, long_clock_tail = 1'b1;
    logic digital_strength_flag = 1'b0, signal_quality_flag = 1'b0, clock_lock_flag = 1'b0;
    logic sel_n, ser_clk, ser_din, battery_monitor_on, wake_timer_on, xtal_keep_on;
    logic baseband_width_rsvd, clock_out_off, clock_out_en, osc32k_on, xtal_osc_on;
    logic valid_data_flag, receiver_chain_on, wake_irq;
    logic [1:0]  band_select, valid_flag_select, amp_gain_sel, wake_exp_reduction;
    logic [3:0]  band_n, band_c, xtal_load_sel, wake_exponent;
    logic [2:0]  baseband_width_sel, strength_threshold_sel;
    logic [11:0] lo_freq_value;
    logic [13:0] wake_mantissa;
    logic [15:0] sync_pattern, cfg = 16'h928A, freq = 16'hAD57, rx = 16'hC080;
    logic [15:0] sync = 16'hC1D4, wake = 16'hE196, wakex = 16'hC300;
    logic [77:0] seen_snap, prev_snap, q[$];
    int          num_checks = 0, fail_count = 0, tail_cnt = 0, n;

    rxcfg_decoder #(.MS_CYCLES(MS)) dut_u (.core_clk, .rst, .sel_n, .ser_clk, .ser_din,
        .slow_clk_on, .duty_cycle_on, .long_clock_tail, .digital_strength_flag,
        .signal_quality_flag, .clock_lock_flag, .band_select, .band_n, .band_c,
        .battery_monitor_on, .wake_timer_on, .xtal_keep_on, .xtal_load_sel,
        .baseband_width_sel, .baseband_width_rsvd, .clock_out_off, .clock_out_en,
        .osc32k_on, .xtal_osc_on, .lo_freq_value, .valid_flag_select, .valid_data_flag,
        .amp_gain_sel, .strength_threshold_sel, .receiver_chain_on, .sync_pattern,
        .wake_mantissa, .wake_exponent, .wake_exp_reduction, .wake_irq);
    rxcfg_host_model host_u (.core_clk(core_clk), .sel_n(sel_n), .ser_clk(ser_clk),
        .ser_din(ser_din));

    always #5 core_clk = ~core_clk;
    assign seen_snap = {band_select, band_n, band_c, battery_monitor_on, wake_timer_on,
        xtal_keep_on, xtal_load_sel, baseband_width_sel, baseband_width_rsvd, clock_out_off,
        lo_freq_value, valid_flag_select, amp_gain_sel, strength_threshold_sel,
        receiver_chain_on, sync_pattern, wake_mantissa, wake_exponent, wake_exp_reduction};
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [77:0] seen, input logic [77:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    // expected settings, built from the shadow words alone
    function automatic logic [77:0] exp_snap();
        logic [7:0] nc;
        case (cfg[12:11])
            2'b01:   nc = 8'h4A;
            2'b10:   nc = 8'h8A;
            2'b11:   nc = 8'h8B;
            default: nc = 8'h00;
        endcase
        return {cfg[12:11], nc, cfg[10:4], cfg[3:1], cfg[3:1] == 3'h0 || cfg[3:1] > 3'h5,
            cfg[0], freq[11:0], rx[7:0], 8'h2D, sync[7:0], wakex[5:0], wake[7:0],
            wake[11:8], wakex[7:6]};
    endfunction : exp_snap
    task automatic put(input logic [15:0] w);
        logic [77:0] b;
        b = exp_snap();
        if (w[15:13] == 3'b100) cfg = w;
        else if (w[15:12] == 4'hA && w[11:0] >= 12'h060 && w[11:0] <= 12'hF3F) freq = w;
        else if (w[15:12] == 4'hE) wake = w;
        else if (w[15:8] == 8'hC0) rx = w;
        else if (w[15:8] == 8'hC1) sync = w;
        else if (w[15:8] == 8'hC3) wakex = w;
        if (exp_snap() !== b) q.push_back(exp_snap());
        host_u.send(w);
        repeat (6) @(posedge core_clk);
        chk(q.size(), 0);
    endtask : put
    // a change in the settings snapshot takes the oldest note; an unnoted change always mismatches
    always @(posedge core_clk) begin
        if (mon_on && seen_snap !== prev_snap) begin
            if (q.size() == 0) chk(seen_snap, prev_snap);
            else chk(seen_snap, q.pop_front());
        end
        prev_snap <= seen_snap;
    end
    always @(posedge core_clk)
        if (xtal_keep_on !== 1'b0) tail_cnt <= 0;
        else if (xtal_osc_on === 1'b1) tail_cnt <= tail_cnt + 1;
    task automatic side_check();
        logic [4:0] r;
        logic       e;
        repeat (4) begin
            r = 5'($urandom);
            @(posedge core_clk);
            {digital_strength_flag, signal_quality_flag, clock_lock_flag, slow_clk_on,
                duty_cycle_on} <= r;
            @(posedge core_clk);
            #1;
            e = (rx[7:6] == 2'b11) ? 1'b1 : r[3'd4 - 3'(rx[7:6])];
            chk(valid_data_flag, e);
            chk(osc32k_on, r[1] | r[0] | cfg[10] | cfg[9]);
            if (rx[0]) chk(xtal_osc_on, 1'b1);
        end
    endtask : side_check
    task automatic irq_gap(output int g);
        int k = 0;
        do begin @(posedge core_clk); #1; k++; end while (wake_irq !== 1'b1 && k < 9000);
        g = 0;
        do begin @(posedge core_clk); #1; g++; end while (wake_irq !== 1'b1 && g < 9000);
    endtask : irq_gap
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [11:0] ftab [6] = '{12'h060, 12'h05F, 12'hF3F, 12'hF40, 12'h000, 12'hFFF};
        logic [15:0] utab [4] = '{16'hCC0E, 16'h0000, 16'hC213, 16'hB0CA};
        logic [19:0] wtab [3] = '{{14'h3, 4'h1, 2'h0}, {14'h5, 4'h2, 2'h1}, {14'h101, 4'h0, 2'h0}};
        logic [13:0] m;
        logic [3:0]  r;
        logic [1:0]  c;
        void'($urandom(58));
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(seen_snap, exp_snap());
        chk(wake_irq, 1'b0);
        mon_on = 1'b1;
        $display("test defaults done");
        for (int b = 0; b < 4; b++) begin put({3'b100, 2'(b), 11'($urandom)}); side_check(); end
        for (int k = 0; k < 6; k++) put({4'hA, ftab[k]});
        put({4'hA, 12'(12'h060 + $urandom % 3808)});
        for (int d = 0; d < 4; d++) begin put({8'hC0, 2'(d), 6'($urandom)}); side_check(); end
        put({8'hC1, 8'($urandom)});
        put({4'hE, 12'($urandom)});
        put({8'hC3, 8'($urandom)});
        for (int k = 0; k < 4; k++) put(utab[k]);
        $display("test commands done");
        put(16'hC080);
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            long_clock_tail <= (k != 1);
            put(k == 2 ? 16'h8983 : 16'h8982);
            chk(clock_out_en, k != 2);
            put(k == 2 ? 16'h8883 : 16'h8882);
            n = 0;
            while (xtal_osc_on !== 1'b0 && n < 1000) begin @(posedge core_clk); n++; end
            n = (k == 0) ? 512 : (k == 1) ? 128 : 0;
            chk(tail_cnt >= n && tail_cnt <= n + 1, 1'b1);
        end
        $display("test clock tail done");
        for (int k = 0; k < 3; k++) begin
            {m, r, c} = wtab[k];
            put(16'h8882);
            put({4'hE, r, m[7:0]});
            put({8'hC3, c, m[13:8]});
            put(16'h8A82);
            irq_gap(n);
            chk(n, ((int'(m) << r) >> c) * MS);
        end
        put(16'h8882);
        n = 0;
        repeat (3000) begin @(posedge core_clk); #1; n += int'(wake_irq === 1'b1); end
        chk(n, 0);
        $display("test wake timer done");
        print_verdict();
    end
    initial begin
        repeat (80000) @(posedge core_clk);
        fail_count++;
        print_verdict();
    end
endmodule : tb_rxcfg_decoder
`default_nettype wire
